// [rtl/fdpc_defs.vh]
// Constants for the front side bus data-phase controller
`ifndef FDPC_DEFS_VH
`define FDPC_DEFS_VH

// ==========================================================
// Widths
`define FDPC_DW        64
`define FDPC_GW        16
`define FDPC_NG        4
`define FDPC_BW        65
`define FDPC_SW        76
`define FDPC_HALF      5'h08

// ==========================================================
// Field positions inside the synchroniser vector
`define FDPC_SB_BCLK   0
`define FDPC_SB_BUSY   1
`define FDPC_SB_VALID  2
`define FDPC_SB_ORDER_N_A  3
`define FDPC_SB_PAR    4
`define FDPC_SB_INV    8
`define FDPC_SB_DATA   12

// ==========================================================
// Driver states, one-hot
`define FDPC_ST_IDLE   3'h1
`define FDPC_ST_DRIVE  3'h2
`define FDPC_ST_REL    3'h4

// ==========================================================
// Reset values
`define FDPC_RST_DATA  64'hFFFFFFFFFFFFFFFF
`define FDPC_RST_GRP   4'hF
`define FDPC_RST_SYNC  76'hFFFFFFFFFFFFFFFFFFE

`endif

// [rtl/fdpc_buf.v]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module fdpc_buf
#(
  parameter W = 65
)
(
  input  wire         clk_in,
  input  wire         sys_rst_in,
  input  wire [W-1:0] in_data_in,
  input  wire         in_valid_in,
  output wire         in_ready_out,
  output wire [W-1:0] out_data_out,
  output wire         out_valid_out,
  input  wire         out_ready_in
);

  reg [W-1:0] mem_r [0:1];
  reg         wptr_r;
  reg         rptr_r;
  reg [1:0]   cnt_r;
  reg         ready_r;
  reg         empty_r;
  wire        push;
  wire        pop;
  wire [1:0]  cnt_nxt;

  // Handshakes on both sides
  assign push          = in_valid_in & ready_r;
  assign pop           = out_ready_in & ~empty_r;
  assign cnt_nxt       = cnt_r + {1'b0, push} - {1'b0, pop};
  assign in_ready_out  = ready_r;
  assign out_valid_out = ~empty_r;
  assign out_data_out  = mem_r[rptr_r];

  // Storage and pointers; flags kept as flops so ready is glitch free
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wptr_r   <= 1'b0;
      rptr_r   <= 1'b0;
      cnt_r    <= 2'h0;
      ready_r  <= 1'b1;
      empty_r  <= 1'b1;
      mem_r[0] <= {W{1'b0}};
      mem_r[1] <= {W{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_r[wptr_r] <= in_data_in;
        wptr_r        <= ~wptr_r;
      end
      if (pop)
        rptr_r <= ~rptr_r;
      cnt_r   <= cnt_nxt;
      ready_r <= (cnt_nxt != 2'h2);
      empty_r <= (cnt_nxt == 2'h0);
    end
  end

endmodule

`default_nettype wire

// [rtl/fdpc_ctrl.v]
// Data-phase control of the front side bus: ownership, valid, parity
//
// Contract
// - The data driver asserts bus-busy while it drives the data bus; this driver keeps its pins one bus clock after busy goes high.
// - The bus counts as free only after bus-busy is seen deasserted.
// - Four parity lines cover the 64 data lines, one per group.
// - Parity lines are driven by whoever drives the data lines.
// - The data driver asserts data-valid on every data transfer.
// - Data-valid may drop mid-burst for idle clocks; receivers skip them.
// - A 16-bit group is inverted when over half its bits drive low.
`timescale 1ns/1ps
`default_nettype none
`include "fdpc_defs.vh"

module fdpc_ctrl
(
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire        bus_clk_in,
  input  wire [63:0] tx_data_in,
  input  wire        tx_last_in,
  input  wire        tx_valid_in,
  output wire        tx_ready_out,
  output reg  [63:0] rx_data_out,
  output reg         rx_valid_out,
  output reg         rx_parity_err_out,
  output reg         order_n_a_out,
  input  wire [63:0] data_n_in,
  output reg  [63:0] data_n_out,
  output reg         data_n_oe_out,
  input  wire [3:0]  group_invert_n_in,
  output reg  [3:0]  group_invert_n_out,
  output reg         group_invert_n_oe_out,
  input  wire [3:0]  data_parity_n_in,
  output reg  [3:0]  data_parity_n_out,
  output reg         data_parity_n_oe_out,
  input  wire        data_bus_busy_n_in,
  output reg         data_bus_busy_n_out,
  output reg         data_bus_busy_n_oe_out,
  input  wire        data_valid_n_in,
  output reg         data_valid_n_out,
  output reg         data_valid_n_oe_out,
  input  wire        order_n_a_in
);

  // ========================================================
  // Declarations
  reg  [`FDPC_SW-1:0] sync1_r;
  reg  [`FDPC_SW-1:0] sync2_r;
  reg                 bclk_prev_r;
  reg  [2:0]          state_r;
  reg                 last_r;
  reg                 seen_free_r;
  wire [`FDPC_SW-1:0] pins;
  wire                rise;
  wire                fall;
  wire [`FDPC_BW-1:0] head;
  wire                head_valid;
  wire                pop;
  wire [63:0]         enc_wire;
  wire [3:0]          enc_inv;
  wire [3:0]          enc_par;
  wire [63:0]         dec_data;
  wire [3:0]          dec_perr;
  wire [63:0]         s_data_n;
  wire [3:0]          s_inv_n;
  wire [3:0]          s_par_n;
  wire                s_busy_n;
  wire                s_valid_n;

  // Count of ones in one data group
  function [4:0] fdpc_ones;
    input [15:0] v;
    integer i;
    begin
      fdpc_ones = 5'h00;
      for (i = 0; i < 16; i = i + 1)
        fdpc_ones = fdpc_ones + {4'h0, v[i]};
    end
  endfunction

  // ========================================================
  // Pin synchroniser: every outside level passes two flops
  assign pins = {data_n_in, group_invert_n_in, data_parity_n_in,
                 order_n_a_in, data_valid_n_in, data_bus_busy_n_in,
                 bus_clk_in};

  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sync1_r     <= `FDPC_RST_SYNC;
      sync2_r     <= `FDPC_RST_SYNC;
      bclk_prev_r <= 1'b0;
    end
    else
    begin
      sync1_r     <= pins;
      sync2_r     <= sync1_r;
      bclk_prev_r <= sync2_r[`FDPC_SB_BCLK];
    end
  end

  // Bus clock edges as one-cycle enables
  assign rise      = sync2_r[`FDPC_SB_BCLK] & ~bclk_prev_r;
  assign fall      = ~sync2_r[`FDPC_SB_BCLK] & bclk_prev_r;
  assign s_data_n  = sync2_r[`FDPC_SB_DATA +: 64];
  assign s_inv_n   = sync2_r[`FDPC_SB_INV +: 4];
  assign s_par_n   = sync2_r[`FDPC_SB_PAR +: 4];
  assign s_busy_n  = sync2_r[`FDPC_SB_BUSY];
  assign s_valid_n = sync2_r[`FDPC_SB_VALID];

  // ========================================================
  // Transmit buffer; a stalled bus back-pressures the source
  fdpc_buf
  #(
    .W (`FDPC_BW)
  )
  u_buf
  (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_data_in    ({tx_last_in, tx_data_in}),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (head),
    .out_valid_out (head_valid),
    .out_ready_in  (pop)
  );

  // ========================================================
  // Per-group encode and decode
  genvar g;
  generate
    for (g = 0; g < `FDPC_NG; g = g + 1)
    begin : grp
      wire [15:0] raw;
      wire [15:0] seen;
      assign raw                 = head[g*16 +: 16];
      assign enc_inv[g]          = (fdpc_ones(raw) > `FDPC_HALF);
      assign enc_wire[g*16 +: 16] = enc_inv[g] ? ~raw : raw;
      assign enc_par[g]          = ^enc_wire[g*16 +: 16];
      // Receive side: undo inversion, check parity on the wire value
      assign seen                = ~s_data_n[g*16 +: 16];
      assign dec_data[g*16 +: 16] = (~s_inv_n[g]) ? ~seen : seen;
      assign dec_perr[g]         = (^seen) != ~s_par_n[g];
    end
  endgenerate

  // ========================================================
  // Pop a word on a bus clock rise when it goes onto the wire
  // Start only on a sampled free bus
  assign pop = rise & head_valid &
               (((state_r == `FDPC_ST_IDLE) & seen_free_r) |
                ((state_r == `FDPC_ST_DRIVE) & ~last_r));

  // ========================================================
  // Driver state machine, advanced on bus clock rises
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r                <= `FDPC_ST_IDLE;
      last_r                 <= 1'b0;
      data_n_out             <= `FDPC_RST_DATA;
      group_invert_n_out     <= `FDPC_RST_GRP;
      data_parity_n_out      <= `FDPC_RST_GRP;
      data_bus_busy_n_out    <= 1'b1;
      data_valid_n_out       <= 1'b1;
      data_n_oe_out          <= 1'b0;
      group_invert_n_oe_out  <= 1'b0;
      data_parity_n_oe_out   <= 1'b0;
      data_bus_busy_n_oe_out <= 1'b0;
      data_valid_n_oe_out    <= 1'b0;
    end
    else if (rise)
    begin
      if (pop)
      begin
        data_n_out         <= ~enc_wire;
        group_invert_n_out <= ~enc_inv;
        data_parity_n_out  <= ~enc_par;
        last_r             <= head[64];
      end
      case (state_r)
        `FDPC_ST_IDLE:
        begin
          if (pop)
          begin
            data_bus_busy_n_out    <= 1'b0;
            data_valid_n_out       <= 1'b0;
            data_n_oe_out          <= 1'b1;
            group_invert_n_oe_out  <= 1'b1;
            data_parity_n_oe_out   <= 1'b1;
            data_bus_busy_n_oe_out <= 1'b1;
            data_valid_n_oe_out    <= 1'b1;
            state_r                <= `FDPC_ST_DRIVE;
          end
        end
        `FDPC_ST_DRIVE:
        begin
          if (last_r)
          begin
            // Busy deasserted while still driven, so others see it high
            data_bus_busy_n_out <= 1'b1;
            data_valid_n_out    <= 1'b1;
            state_r             <= `FDPC_ST_REL;
          end
          else
          begin
            data_valid_n_out <= ~pop;
          end
        end
        `FDPC_ST_REL:
        begin
          data_n_oe_out          <= 1'b0;
          group_invert_n_oe_out  <= 1'b0;
          data_parity_n_oe_out   <= 1'b0;
          data_bus_busy_n_oe_out <= 1'b0;
          data_valid_n_oe_out    <= 1'b0;
          last_r                 <= 1'b0;
          state_r                <= `FDPC_ST_IDLE;
        end
        default:
        begin
          state_r <= `FDPC_ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // Mid-period sampling on bus clock falls, clear of edge skew
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      seen_free_r       <= 1'b0;
      rx_data_out       <= 64'h0000000000000000;
      rx_valid_out      <= 1'b0;
      rx_parity_err_out <= 1'b0;
      order_n_a_out         <= 1'b0;
    end
    else
    begin
      rx_valid_out <= 1'b0;
      if (fall)
      begin
        // Free only once busy is high
        seen_free_r <= s_busy_n & s_valid_n &
                       (state_r == `FDPC_ST_IDLE);
        order_n_a_out   <= ~sync2_r[`FDPC_SB_ORDER_N_A];
        if (~s_valid_n & (state_r == `FDPC_ST_IDLE))
        begin
          rx_data_out       <= dec_data;
          rx_valid_out      <= 1'b1;
          rx_parity_err_out <= |dec_perr;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [tb/fdpc_ctrl_properties.sv]
// Checker of the data-phase controller's pin behaviour
`timescale 1ns/1ps
`default_nettype none
module fdpc_ctrl_chk (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [63:0] data_n_out,
  input wire logic        data_n_oe_out,
  input wire logic [3:0]  data_parity_n_out,
  input wire logic        data_parity_n_oe_out,
  input wire logic        data_bus_busy_n_in,
  input wire logic        data_bus_busy_n_out,
  input wire logic        data_bus_busy_n_oe_out,
  input wire logic        data_valid_n_out,
  input wire logic        rx_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Parity pins expected per group; bit 4 low if a group has >8 low wires
  function automatic logic [4:0] grp(input logic [63:0] d);
    grp = 5'h10;
    for (int g = 0; g < 4; g++)
    begin
      grp[g] = ~^d[16*g +: 16];
      if ($countones(~d[16*g +: 16]) > 8) grp[4] = 1'b0;
    end
  endfunction
  wire [4:0] g_w = grp(data_n_out);
  wire       drv = data_n_oe_out && !data_valid_n_out;
  // ======
  // Assertions
  a_busy_owns: assert property (
    !data_bus_busy_n_out |-> data_bus_busy_n_oe_out) else $error("busy");
  a_valid_busy: assert property (
    drv |-> !data_bus_busy_n_out) else $error("valid without busy");
  a_par_owner: assert property (
    data_parity_n_oe_out == data_n_oe_out) else $error("parity owner");
  a_par_even: assert property (
    drv |-> data_parity_n_out == g_w[3:0]) else $error("parity value");
  a_inv_limit: assert property (
    drv |-> g_w[4]) else $error("group not inverted");
  a_rel_gap: assert property (
    $fell(data_bus_busy_n_oe_out) |-> data_bus_busy_n_out
      && $past(data_bus_busy_n_out)) else $error("release early");
  a_start_free: assert property (
    $rose(data_bus_busy_n_oe_out) |-> $past(data_bus_busy_n_in))
    else $error("start on busy bus");
  a_rx_once: assert property (
    rx_valid_out |=> !rx_valid_out) else $error("rx pulse long");
  cover property (drv);
  cover property (rx_valid_out);
  cover property ($fell(data_bus_busy_n_oe_out));
endmodule
bind fdpc_ctrl fdpc_ctrl_chk chk (.clk_in, .sys_rst_in, .data_n_out,
  .data_n_oe_out, .data_parity_n_out, .data_parity_n_oe_out,
  .data_bus_busy_n_in, .data_bus_busy_n_out, .data_bus_busy_n_oe_out,
  .data_valid_n_out, .rx_valid_out);
`default_nettype wire

// [tb/fdpc_agent.sv]
// Bus agent model facing the data-phase controller
`timescale 1ns/1ps
`default_nettype none
module fdpc_agent (
  input wire logic        bus_clk_in,
  input wire logic        busy_n_in,
  input wire logic        valid_n_in,
  input wire logic [63:0] data_n_in,
  input wire logic [3:0]  inv_n_in,
  output logic     [63:0] data_n_out,
  output logic     [3:0]  par_n_out,
  output logic            busy_n_out,
  output logic            valid_n_out,
  output logic            oe_out,
  output logic            order_n_a_n_out
);
  logic [67:0] rxq[$];
  initial {busy_n_out, valid_n_out, oe_out, order_n_a_n_out} = 4'hD;
  // Take foreign words mid-period, inversion undone
  always @(negedge bus_clk_in)
    if (!valid_n_in && !oe_out)
      rxq.push_back({inv_n_in, ~data_n_in ^ {{16{~inv_n_in[3]}},
        {16{~inv_n_in[2]}}, {16{~inv_n_in[1]}}, {16{~inv_n_in[0]}}}});
  // Never inverts; bad flips group 0 parity on purpose
  task automatic put(input logic [63:0] w, input logic bad);
    data_n_out = ~w;
    par_n_out = ~{^w[63:48], ^w[47:32], ^w[31:16], ^w[15:0]} ^ {3'h0, bad};
  endtask
  // Two-word burst once the bus is seen free
  task automatic send(input logic [63:0] a, b, input logic gap, bad);
    int n;
    n = 0;
    // wait bus free for two clocks; an owner keeps its
    // pins one clock after dropping busy
    while (n < 2)
    begin
      @(posedge bus_clk_in);
      n = (busy_n_in && valid_n_in) ? n + 1 : 0;
    end
    {oe_out, busy_n_out, valid_n_out} = 3'h4;
    put(a, bad);
    if (gap)
    begin
      @(posedge bus_clk_in) valid_n_out = 1'b1;
      data_n_out = ~data_n_out;
    end
    @(posedge bus_clk_in) valid_n_out = 1'b0;
    put(b, 1'b0);
    @(posedge bus_clk_in) {busy_n_out, valid_n_out} = 2'h3;
    data_n_out = ~data_n_out;
    @(posedge bus_clk_in) oe_out = 1'b0;
  endtask
  task automatic set_order_n_a(input logic v);
    @(posedge bus_clk_in) order_n_a_n_out = ~v;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the data-phase controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [63:0] ones = 64'hFFFFFFFFFFFFFFFF;
  logic clk_in = 0, sys_rst_in = 1, bus_clk = 0, tx_last = 0, tx_valid = 0;
  logic [63:0] tx_data = 64'h0, txw[4];
  logic [67:0] rxd[$];
  int error_cnt = 0, cmp_count = 0, coll = 0;
  wire [63:0] rx_data, d_o, d_w, a_d;
  wire [3:0]  i_o, p_o, i_w, p_w, a_p;
  wire tx_ready, rx_valid, rx_perr, order_n_a, d_oe, i_oe, p_oe, b_o, b_oe;
  wire v_o, v_oe, a_b, a_v, a_oe, a_def, b_w, v_w;
  // Terminated lines float high when nobody drives
  assign d_w = d_oe ? d_o : a_oe ? a_d : ones;
  assign i_w = i_oe ? i_o : 4'hF;
  assign p_w = p_oe ? p_o : a_oe ? a_p : 4'hF;
  assign b_w = b_oe ? b_o : a_oe ? a_b : 1'b1;
  assign v_w = v_oe ? v_o : a_oe ? a_v : 1'b1;
  always #5 clk_in = ~clk_in;
  initial
  begin
    #2.3;
    forever #40 bus_clk = ~bus_clk;
  end
  fdpc_ctrl dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .bus_clk_in(bus_clk), .tx_data_in(tx_data), .tx_last_in(tx_last),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid), .rx_parity_err_out(rx_perr),
    .order_n_a_out(order_n_a), .data_n_in(d_w), .data_n_out(d_o),
    .data_n_oe_out(d_oe), .group_invert_n_in(i_w),
    .group_invert_n_out(i_o), .group_invert_n_oe_out(i_oe),
    .data_parity_n_in(p_w), .data_parity_n_out(p_o),
    .data_parity_n_oe_out(p_oe), .data_bus_busy_n_in(b_w),
    .data_bus_busy_n_out(b_o), .data_bus_busy_n_oe_out(b_oe),
    .data_valid_n_in(v_w), .data_valid_n_out(v_o),
    .data_valid_n_oe_out(v_oe), .order_n_a_in(a_def));
  fdpc_agent ag (.bus_clk_in(bus_clk), .busy_n_in(b_w), .valid_n_in(v_w),
    .data_n_in(d_w), .inv_n_in(i_w), .data_n_out(a_d), .par_n_out(a_p),
    .busy_n_out(a_b), .valid_n_out(a_v), .oe_out(a_oe),
    .order_n_a_n_out(a_def));
  // Received words and bus fights seen on the system clock
  always @(posedge clk_in)
  begin
    if (rx_valid === 1'b1) rxd.push_back({3'h0, rx_perr, rx_data});
    if (d_oe === 1'b1 && a_oe) coll++;
  end
  task check(input logic [67:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Group pins stay high unless more than eight ones
  function automatic logic [67:0] expw(input logic [63:0] w);
    logic [3:0] inv;
    for (int g = 0; g < 4; g++) inv[g] = $countones(w[16*g +: 16]) <= 8;
    return {inv, w};
  endfunction
  // Four words back to back; the two-entry buffer must stall
  task t_tx;
    int st;
    st = 0;
    for (int k = 0; k < 4; k++)
    begin
      tx_data <= txw[k];
      tx_last <= (k == 3);
      tx_valid <= 1'b1;
      @(posedge clk_in);
      while (!tx_ready)
      begin
        st++;
        @(posedge clk_in);
      end
    end
    tx_valid <= 1'b0;
    check(st > 0, 1'b1);
    for (int i = 0; i < 400 && ag.rxq.size() < 4; i++) @(posedge clk_in);
    for (int k = 0; k < 4; k++) check(ag.rxq.pop_front(), expw(txw[k]));
    repeat (40) @(posedge clk_in);
    check({b_w, d_oe, b_oe}, 3'h4);
  endtask
  // Source pauses mid-burst; the bus must show idle clocks
  task t_gap;
    tx_data <= 64'h00FF00FF00FF00FF;
    tx_last <= 1'b0;
    tx_valid <= 1'b1;
    @(posedge clk_in);
    while (!tx_ready) @(posedge clk_in);
    tx_valid <= 1'b0;
    repeat (30) @(posedge clk_in);
    check(ag.rxq.size(), 1);
    tx_data <= 64'hFFFF0000FFFF0000;
    tx_last <= 1'b1;
    tx_valid <= 1'b1;
    @(posedge clk_in);
    while (!tx_ready) @(posedge clk_in);
    tx_valid <= 1'b0;
    for (int i = 0; i < 100 && ag.rxq.size() < 2; i++) @(posedge clk_in);
    check(ag.rxq.pop_front(), expw(64'h00FF00FF00FF00FF));
    check(ag.rxq.pop_front(), expw(64'hFFFF0000FFFF0000));
    repeat (40) @(posedge clk_in);
  endtask
  // Far agent owns the bus with an idle clock while a word waits
  task t_rx;
    rxd.delete();
    fork
      ag.send(64'h0123456789ABCDEF, 64'hFEDCBA9876543210, 1'b1, 1'b0);
      begin
        repeat (20) @(posedge clk_in);
        tx_data <= 64'h00000000FFFF0000;
        tx_valid <= 1'b1;
        @(posedge clk_in);
        while (!tx_ready) @(posedge clk_in);
        tx_valid <= 1'b0;
      end
    join
    for (int i = 0; i < 300 && ag.rxq.size() < 1; i++) @(posedge clk_in);
    check(rxd.size(), 2);
    check(rxd[1], {4'h0, 64'hFEDCBA9876543210});
    check(ag.rxq.pop_front(), expw(64'h00000000FFFF0000));
    check(coll, 0);
  endtask
  // First word carries bad parity, second is clean
  task t_par;
    rxd.delete();
    ag.send(64'h5555AAAA0F0F1234, 64'h1, 1'b0, 1'b1);
    repeat (20) @(posedge clk_in);
    check(rxd[0][67:64], 4'h1);
    check(rxd[1][67:64], 4'h0);
    check(coll, 0);
  endtask
  task t_def;
    ag.set_order_n_a(1'b1);
    repeat (24) @(posedge clk_in);
    check(order_n_a, 1'b1);
    ag.set_order_n_a(1'b0);
    repeat (24) @(posedge clk_in);
    check(order_n_a, 1'b0);
  endtask
  initial
  begin
    txw = '{64'h000000FF01FFFFFF, 64'h01FF00FFFFFF0000,
      64'h80007FFF0001FFFE, 64'h0};
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    // Idle pins, buffer ready after reset
    check({d_oe, i_oe, p_oe, b_oe, v_oe, tx_ready, rx_valid, order_n_a}, 8'h04);
    t_tx;
    t_gap;
    t_rx;
    t_par;
    t_def;
    end_sim;
  end
  // Watchdog cuts a hang short
  initial
  begin
    #200000;
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
